//--- src/eets_defs.svh
`ifndef EETS_DEFS_SVH
`define EETS_DEFS_SVH
// stored word layout
`define EETS_DATA_W      64
`define EETS_CHK_W       8
`define EETS_WORD_W      72
// channel / rank organisation
`define EETS_NCH         2
`define EETS_NRANK       2
`define EETS_NCNT        4
`define EETS_CNT_W       5
// memory address width for patrol walk
`define EETS_ADDR_W      16
`define EETS_ADDR_MAX    16'hFFFF
// threshold settings
`define EETS_THR_20      5'h14
`define EETS_THR_10      5'h0A
`define EETS_THR_5       5'h05
`define EETS_THR_ALL     5'h01
// leak and patrol period width
`define EETS_PER_W       32
`endif

//--- src/eets_pkg.sv
package eets_pkg;
  typedef enum logic [2:0] {
    EETS_THR_SEL_20   = 3'h0,
    EETS_THR_SEL_10   = 3'h1,
    EETS_THR_SEL_5    = 3'h2,
    EETS_THR_SEL_ALL  = 3'h3,
    EETS_THR_SEL_NONE = 3'h4
  } eets_thr_e;

  typedef enum logic [3:0] {
    EETS_IDLE   = 4'b0001,
    EETS_RD     = 4'b0010,
    EETS_WAIT   = 4'b0100,
    EETS_WB     = 4'b1000
  } eets_state_e;
endpackage : eets_pkg

//--- src/eets_top.sv
`timescale 1ns/100ps
`include "eets_defs.svh"
module eets_top (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  // configuration
  input  wire logic [2:0]                thr_sel,
  input  wire logic                      demand_scrub_dis,
  input  wire logic                      patrol_en,
  input  wire logic [`EETS_PER_W-1:0]    leak_period,
  input  wire logic [`EETS_PER_W-1:0]    patrol_period,
  // host read request
  input  wire logic                      rd_req,
  input  wire logic [`EETS_ADDR_W-1:0]   rd_addr,
  input  wire logic [0:0]                rd_ch,
  input  wire logic [0:0]                rd_rank,
  output logic                           rd_ack,
  output logic                           rd_valid,
  output logic [`EETS_DATA_W-1:0]        rd_data,
  // host write request
  input  wire logic                      wr_req,
  input  wire logic [`EETS_ADDR_W-1:0]   wr_addr,
  input  wire logic [`EETS_DATA_W-1:0]   wr_data,
  input  wire logic [0:0]                wr_ch,
  input  wire logic [0:0]                wr_rank,
  output logic                           wr_ack,
  // memory side
  output logic                           mem_rd,
  output logic                           mem_wr,
  output logic [`EETS_ADDR_W-1:0]        mem_addr,
  output logic [0:0]                     mem_ch,
  output logic [0:0]                     mem_rank,
  output logic [`EETS_WORD_W-1:0]        mem_wdata,
  input  wire logic                      mem_rvalid,
  input  wire logic [`EETS_WORD_W-1:0]   mem_rdata,
  // events and indicators
  output logic                           log_event,
  output logic                           log_fatal,
  output logic                           machine_check_exception,
  output logic [`EETS_NCNT-1:0]          slot_fault,
  output logic                           status_amber,
  output logic                           ce_pulse,
  output logic                           multi_bit_error
);

  logic rst_s1_q, rst_s_b;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s_b  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s_b  <= rst_s1_q;
    end
  end

  // hamming position of data bit i (skip powers of two), 3..71
  function automatic logic [6:0] dpos(input int i);
    int p;
    int k;
    p = 0;
    k = -1;
    for (int n = 1; n < 72; n++) begin
      if ((n & (n - 1)) != 0) begin
        k = k + 1;
        if (k == i) p = n;
      end
    end
    return p[6:0];
  endfunction : dpos

  // 7 hamming bits plus overall parity
  function automatic logic [7:0] enc(input logic [63:0] d);
    logic [7:0] c;
    logic [6:0] pos;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
      pos = dpos(i);
      if (d[i]) c[6:0] = c[6:0] ^ pos;
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction : enc

  // decode: syndrome and overall parity
  logic [`EETS_DATA_W-1:0] rx_d;
  logic [`EETS_CHK_W-1:0]  rx_c;
  logic [7:0]              chk_calc;
  logic [6:0]              syn;
  logic                    par_err, ce_det, ue_det;
  logic [`EETS_DATA_W-1:0] fix_d;
  always_comb begin
    rx_d     = mem_rdata[`EETS_DATA_W-1:0];
    rx_c     = mem_rdata[`EETS_WORD_W-1:`EETS_DATA_W];
    chk_calc = enc(rx_d);
    syn      = chk_calc[6:0] ^ rx_c[6:0];
    par_err  = ^{rx_d, rx_c};
    ce_det   = par_err;
    ue_det   = !par_err && (syn != 7'h00);
    fix_d    = rx_d;
    for (int i = 0; i < 64; i++) begin
      if (par_err && syn == dpos(i)) fix_d[i] = ~rx_d[i];
    end
  end

  // access sequencer
  eets_pkg::eets_state_e st_q, st_d;
  logic [`EETS_ADDR_W-1:0] addr_q, addr_d;
  logic [0:0]              ch_q, ch_d, rk_q, rk_d;
  logic                    patrol_q, patrol_d;
  logic [`EETS_DATA_W-1:0] fix_q, fix_nd;
  logic [`EETS_DATA_W-1:0] rdat_q, rdat_d;
  logic                    rval_q, rval_d;
  logic                    ce_ev, ue_ev;
  logic [1:0]              ev_idx;
  logic                    patrol_due, patrol_go, demand_en;
  logic [`EETS_ADDR_W-1:0] paddr_q, paddr_d;
  logic [1:0]              psel_q, psel_d;
  assign demand_en = !demand_scrub_dis;

  always_comb begin
    st_d      = st_q;
    addr_d    = addr_q;
    ch_d      = ch_q;
    rk_d      = rk_q;
    patrol_d  = patrol_q;
    fix_nd    = fix_q;
    rdat_d    = rdat_q;
    rval_d    = 1'b0;
    rd_ack    = 1'b0;
    wr_ack    = 1'b0;
    patrol_go = 1'b0;
    mem_rd    = 1'b0;
    mem_wr    = 1'b0;
    mem_addr  = addr_q;
    mem_ch    = ch_q;
    mem_rank  = rk_q;
    mem_wdata = {enc(fix_q), fix_q};
    ce_ev     = 1'b0;
    ue_ev     = 1'b0;
    case (st_q)
      eets_pkg::EETS_IDLE: begin
        if (wr_req) begin
          wr_ack    = 1'b1;
          mem_wr    = 1'b1;
          mem_addr  = wr_addr;
          mem_ch    = wr_ch;
          mem_rank  = wr_rank;
          mem_wdata = {enc(wr_data), wr_data};
        end else if (rd_req) begin
          rd_ack   = 1'b1;
          addr_d   = rd_addr;
          ch_d     = rd_ch;
          rk_d     = rd_rank;
          patrol_d = 1'b0;
          st_d     = eets_pkg::EETS_RD;
        end else if (patrol_due) begin
          patrol_go = 1'b1;
          patrol_d  = 1'b1;
          addr_d    = paddr_q;
          ch_d      = psel_q[1];
          rk_d      = psel_q[0];
          st_d      = eets_pkg::EETS_RD;
        end
      end
      eets_pkg::EETS_RD: begin
        mem_rd = 1'b1;
        st_d   = eets_pkg::EETS_WAIT;
      end
      eets_pkg::EETS_WAIT: begin
        if (mem_rvalid) begin
          ce_ev  = ce_det;
          ue_ev  = ue_det;
          fix_nd = fix_d;
          if (!patrol_q) begin
            rval_d = 1'b1;
            rdat_d = fix_d;
          end
          if (ce_det && (patrol_q || demand_en)) begin
            st_d = eets_pkg::EETS_WB;
          end else begin
            st_d = eets_pkg::EETS_IDLE;
          end
        end
      end
      eets_pkg::EETS_WB: begin
        mem_wr = 1'b1;
        st_d   = eets_pkg::EETS_IDLE;
      end
      default: st_d = eets_pkg::EETS_IDLE;
    endcase
  end

  // patrol walk with interval timer
  logic [`EETS_PER_W-1:0]  ptim_q, ptim_d;
  logic                    pdue_q, pdue_d;
  assign patrol_due = pdue_q;
  always_comb begin
    ptim_d  = ptim_q;
    pdue_d  = pdue_q;
    paddr_d = paddr_q;
    psel_d  = psel_q;
    if (!patrol_en) begin
      ptim_d = '0;
      pdue_d = 1'b0;
    end else if (!pdue_q) begin
      if (ptim_q >= patrol_period) begin
        ptim_d = '0;
        pdue_d = 1'b1;
      end else begin
        ptim_d = ptim_q + 1'b1;
      end
    end
    if (patrol_go) begin
      pdue_d = 1'b0;
      psel_d = psel_q + 2'h1;
      if (psel_q == 2'h3) begin
        paddr_d = (paddr_q == `EETS_ADDR_MAX) ? '0 : paddr_q + 1'b1;
      end
    end
  end

  // per channel/rank leaky bucket counters
  logic [`EETS_NCNT-1:0][`EETS_CNT_W-1:0] cnt_q, cnt_d;
  logic [`EETS_NCNT-1:0]                  hit_q, hit_d;
  logic [`EETS_NCNT-1:0]                  slot_q, slot_d;
  logic [`EETS_PER_W-1:0]                 ltim_q, ltim_d;
  logic                                   leak_tick, thr_none;
  logic [`EETS_CNT_W-1:0]                 thr_val;
  logic                                   log_d, fat_d, amb_d;
  logic                                   log_q, fat_q, amb_q;
  logic                                   ce_q, ue_q;
  assign ev_idx = {ch_q, rk_q};

  always_comb begin
    thr_none = 1'b0;
    case (thr_sel)
      eets_pkg::EETS_THR_SEL_20:  thr_val = `EETS_THR_20;
      eets_pkg::EETS_THR_SEL_10:  thr_val = `EETS_THR_10;
      eets_pkg::EETS_THR_SEL_5:   thr_val = `EETS_THR_5;
      eets_pkg::EETS_THR_SEL_ALL: thr_val = `EETS_THR_ALL;
      default: begin
        thr_val  = `EETS_THR_20;
        thr_none = 1'b1;
      end
    endcase
  end

  always_comb begin
    ltim_d    = ltim_q + 1'b1;
    leak_tick = 1'b0;
    if (ltim_q >= leak_period) begin
      ltim_d    = '0;
      leak_tick = 1'b1;
    end
  end

  // every-error setting keeps reporting; otherwise first crossing latches
  genvar g;
  generate
    for (g = 0; g < `EETS_NCNT; g++) begin : g_cnt
      always_comb begin
        cnt_d[g]  = cnt_q[g];
        hit_d[g]  = hit_q[g];
        slot_d[g] = slot_q[g];
        if (leak_tick && cnt_q[g] != '0 && !hit_q[g]) begin
          cnt_d[g] = cnt_q[g] - 1'b1;
        end
        if (ce_ev && ev_idx == g && !hit_q[g] && !thr_none) begin
          cnt_d[g] = cnt_q[g] + 1'b1;
          if (cnt_q[g] + 1'b1 >= thr_val) begin
            slot_d[g] = 1'b1;
            cnt_d[g]  = (thr_sel == eets_pkg::EETS_THR_SEL_ALL) ? '0 : thr_val;
            hit_d[g]  = (thr_sel != eets_pkg::EETS_THR_SEL_ALL);
          end
        end
        if (ue_ev && ev_idx == g) slot_d[g] = 1'b1;
      end
    end
  endgenerate

  always_comb begin
    log_d = 1'b0;
    fat_d = 1'b0;
    amb_d = amb_q;
    if (ce_ev && !thr_none && !hit_q[ev_idx] && cnt_q[ev_idx] + 1'b1 >= thr_val) begin
      log_d = 1'b1;
    end
    if (ue_ev) begin
      log_d = 1'b1;
      fat_d = 1'b1;
      amb_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_b) begin
    if (!rst_s_b) begin
      st_q <= eets_pkg::EETS_IDLE;
      {addr_q, ch_q, rk_q, patrol_q, fix_q, rdat_q, rval_q, ptim_q, pdue_q} <= '0;
      {paddr_q, psel_q, cnt_q, hit_q, slot_q, ltim_q, log_q, fat_q, amb_q, ce_q, ue_q} <= '0;
    end else begin
      st_q <= st_d;
      {addr_q, ch_q, rk_q, patrol_q, fix_q} <= {addr_d, ch_d, rk_d, patrol_d, fix_nd};
      {rdat_q, rval_q, ptim_q, pdue_q, paddr_q} <= {rdat_d, rval_d, ptim_d, pdue_d, paddr_d};
      {psel_q, cnt_q, hit_q, slot_q, ltim_q} <= {psel_d, cnt_d, hit_d, slot_d, ltim_d};
      {log_q, fat_q, amb_q, ce_q, ue_q} <= {log_d, fat_d, amb_d, ce_ev, ue_ev};
    end
  end

  assign rd_valid                = rval_q;
  assign rd_data                 = rdat_q;
  assign log_event               = log_q;
  assign log_fatal               = fat_q;
  assign machine_check_exception = fat_q;
  assign slot_fault              = slot_q;
  assign status_amber            = amb_q;
  assign ce_pulse                = ce_q;
  assign multi_bit_error         = ue_q;
endmodule : eets_top

//--- test/eets_top_props.sv
`timescale 1ns/100ps
module eets_top_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // settings
  input wire logic [2:0] thr_sel,
  input wire logic       demand_scrub_dis,
  // transfers
  input wire logic       rd_ack,
  input wire logic       rd_valid,
  input wire logic       mem_rd,
  input wire logic       mem_wr,
  // events
  input wire logic       ce_pulse,
  input wire logic       multi_bit_error,
  input wire logic       log_event,
  input wire logic       log_fatal,
  input wire logic       machine_check_exception,
  input wire logic [3:0] slot_fault,
  input wire logic       status_amber
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_host_ce;
    rd_valid && ce_pulse;
  endsequence
  sequence s_ue_amber;
    multi_bit_error ##1 status_amber;
  endsequence
  a_ack_then_read: assert property (rd_ack |=> mem_rd)
    else $error("no memory read after ack");
  a_demand_wb: assert property (s_host_ce ##0 !demand_scrub_dis |-> mem_wr)
    else $error("no write back");
  a_ue_flags: assert property (multi_bit_error |-> log_fatal && machine_check_exception)
    else $error("fatal flags missing");
  a_ue_amber: assert property (multi_bit_error |-> s_ue_amber)
    else $error("status not amber");
  a_fault_holds: assert property (|slot_fault |=>
    (slot_fault & $past(slot_fault)) == $past(slot_fault)) else $error("fault cleared");
  a_log_cause: assert property (log_event |-> ce_pulse || multi_bit_error)
    else $error("log without error");
  a_every_logs: assert property (ce_pulse && thr_sel == 3'h3 |-> log_event)
    else $error("every mode silent");
  a_none_quiet: assert property (ce_pulse && thr_sel[2] |-> !log_event)
    else $error("none mode logged");
endmodule : eets_top_props

//--- test/eets_mem_model.sv
`timescale 1ns/100ps
module eets_mem_model #(
  parameter int LAT = 2
) (
  // clock
  input  wire logic        clk_sys,
  // request
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [0:0]  mem_ch,
  input  wire logic [0:0]  mem_rank,
  input  wire logic [71:0] mem_wdata,
  // read return
  output logic             mem_rvalid,
  output logic [71:0]      mem_rdata
);
  logic [71:0]  mem [2**18];
  logic [LAT:0] pipe;
  logic [17:0]  ra;
  initial begin
    pipe = '0;
    ra = '0;
    foreach (mem[i]) mem[i] = '0;
  end
  always @(posedge clk_sys) begin
    pipe <= {pipe[LAT-1:0], mem_rd};
    if (mem_rd) ra <= {mem_ch, mem_rank, mem_addr};
    if (mem_wr) mem[{mem_ch, mem_rank, mem_addr}] <= mem_wdata;
  end
  // data line is inverted outside the return cycle
  assign mem_rvalid = pipe[LAT-1];
  assign mem_rdata = mem_rvalid ? mem[ra] : ~mem[ra];
endmodule : eets_mem_model

//--- test/eets_top_test.sv
`timescale 1ns/100ps
module eets_top_test;
  localparam logic [63:0] D = 64'hA5A5_0F0F_3C3C_9696;
  logic clk_sys, rst_b, patrol_en, demand_scrub_dis, rd_req, wr_req, rd_ack, wr_ack;
  logic rd_valid, mem_rd, mem_wr, mem_rvalid, ce_pulse, log_event, log_fatal;
  logic machine_check_exception, status_amber, multi_bit_error, ce, lg, ue;
  logic [0:0]  rd_ch, rd_rank, wr_ch, wr_rank, mem_ch, mem_rank;
  logic [2:0]  thr_sel;
  logic [1:0]  ft;
  logic [3:0]  slot_fault;
  logic [15:0] rd_addr, wr_addr, mem_addr;
  logic [31:0] leak_period, patrol_period;
  logic [63:0] rd_data, wr_data, got;
  logic [71:0] mem_wdata, mem_rdata, wdw;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  eets_top uut (.clk_sys, .rst_b, .thr_sel, .demand_scrub_dis, .patrol_en, .leak_period,
    .patrol_period, .rd_req, .rd_addr, .rd_ch, .rd_rank, .rd_ack, .rd_valid, .rd_data,
    .wr_req, .wr_addr, .wr_data, .wr_ch, .wr_rank, .wr_ack, .mem_rd, .mem_wr, .mem_addr,
    .mem_ch, .mem_rank, .mem_wdata, .mem_rvalid, .mem_rdata, .log_event, .log_fatal,
    .machine_check_exception, .slot_fault, .status_amber, .ce_pulse, .multi_bit_error);
  eets_mem_model mem_i (.clk_sys, .mem_rd, .mem_wr, .mem_addr, .mem_ch, .mem_rank,
    .mem_wdata, .mem_rvalid, .mem_rdata);

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  function automatic logic [71:0] enc(input logic [63:0] d);
    logic [7:0] c;
    int         j;
    c = '0;
    j = 0;
    for (int p = 3; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < 7; i++) c[i] ^= p[i] & d[j];
        j++;
      end
    end
    c[7] = ^{c[6:0], d};
    return {c, d};
  endfunction : enc

  task automatic chk(input string nm, input logic [71:0] s, input logic [71:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // request held until its ack is seen, released on the taking edge
  task automatic acc(input logic w, input logic [17:0] a);
    @(posedge clk_sys);
    if (w) {wr_ch, wr_rank, wr_addr, wr_req} <= {a, 1'b1};
    else {rd_ch, rd_rank, rd_addr, rd_req} <= {a, 1'b1};
    @(negedge clk_sys);
    for (int i = 0; i < 50 && (w ? wr_ack : rd_ack) !== 1'b1; i++) @(negedge clk_sys);
    wdw = mem_wdata;
    @(posedge clk_sys);
    {wr_req, rd_req} <= 2'b00;
    for (int i = 0; i < 50 && !w && rd_valid !== 1'b1; i++) @(negedge clk_sys);
    if (!w) {got, ce, lg, ue, ft} = {rd_data, ce_pulse, log_event, multi_bit_error, log_fatal,
      machine_check_exception};
    @(negedge clk_sys);
  endtask : acc

  task automatic bad_rd(input logic [17:0] a, input logic [71:0] m);
    mem_i.mem[a] = mem_i.mem[a] ^ m;
    acc(1'b0, a);
  endtask : bad_rd

  task automatic thr_run(input logic [2:0] sel, input logic [17:0] a, input int n);
    @(posedge clk_sys);
    thr_sel <= sel;
    acc(1'b1, a);
    for (int k = 1; k <= n + 1; k++) begin
      bad_rd(a, 72'h1 << k);
      chk("ce_read", {got, ce, lg, ft}, {D, 1'b1, k == n, 2'b00});
      chk("scrubbed", mem_i.mem[a], enc(D));
    end
    chk("slot_fault", slot_fault[a[17:16]], 1'b1);
    $display("done threshold %0d", n);
  endtask : thr_run

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    {clk_sys, rst_b, patrol_en, demand_scrub_dis, rd_req, wr_req} = '0;
    {rd_ch, rd_rank, rd_addr, wr_ch, wr_rank, wr_addr} = '0;
    {thr_sel, leak_period, patrol_period, wr_data} = {3'h2, 32'hFFFF_FFFF, 32'h0000_0014, D};
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    acc(1'b1, 18'h0_0010);
    chk("encode", wdw, enc(D));
    acc(1'b0, 18'h0_0010);
    chk("clean", {got, ce, ue, ft, status_amber, slot_fault}, {D, 9'h000});
    $display("done write and read");
    thr_run(3'h2, 18'h0_0010, 5);
    thr_run(3'h1, 18'h2_0010, 10);
    thr_run(3'h0, 18'h3_0010, 20);
    acc(1'b1, 18'h1_0010);
    bad_rd(18'h1_0010, 72'h3);
    chk("fatal", {ue, lg, ft, status_amber, slot_fault}, 9'h1FF);
    acc(1'b1, 18'h1_0010);
    @(posedge clk_sys);
    thr_sel <= 3'h3;
    for (int k = 64; k < 66; k++) begin
      bad_rd(18'h1_0010, 72'h1 << k);
      chk("every", {got, lg}, {D, 1'b1});
    end
    $display("done fatal and every");
    @(posedge clk_sys);
    {thr_sel, leak_period} <= {3'h2, 32'h0000_0014};
    for (int k = 0; k < 8; k++) begin
      if (k == 4) repeat (120) @(posedge clk_sys);
      bad_rd(18'h1_0010, 72'h1 << k);
      chk("leak", lg, 1'b0);
    end
    $display("done leak");
    @(posedge clk_sys);
    {thr_sel, demand_scrub_dis} <= {3'h4, 1'b1};
    bad_rd(18'h1_0010, 72'h80);
    chk("kept", {lg, mem_i.mem[18'h1_0010] === enc(D)}, 2'b00);
    acc(1'b0, 18'h1_0010);
    chk("again", {got, ce}, {D, 1'b1});
    $display("done demand off");
    mem_i.mem[18'h2_0000] = 72'h10;
    @(posedge clk_sys);
    patrol_en <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      @(negedge clk_sys);
      for (int i = 0; i < 100 && mem_rd !== 1'b1; i++) @(negedge clk_sys);
      chk("walk", {mem_addr, mem_ch, mem_rank}, k);
    end
    @(posedge clk_sys);
    patrol_en <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("patrol", mem_i.mem[18'h2_0000], 72'h0);
    $display("done patrol");
    finish_test();
  end
endmodule : eets_top_test

bind eets_top eets_top_props props_i (.clk_sys, .rst_b, .thr_sel, .demand_scrub_dis, .rd_ack,
  .rd_valid, .mem_rd, .mem_wr, .ce_pulse, .multi_bit_error, .log_event, .log_fatal,
  .machine_check_exception, .slot_fault, .status_amber);
